// ### design/pmicr_pkg.sv
// Package with register map, field layout, reset values and shared types of the regulator register slice.
package pmicr_pkg;

  localparam logic [7:0] ADDR_DISCH = 8'hAD;
  localparam logic [7:0] ADDR_A1CTL = 8'hAE;
  localparam logic [7:0] ADDR_PG1 = 8'hB0;
  localparam logic [7:0] ADDR_PG2 = 8'hB1;
  localparam logic [7:0] ADDR_FLT1 = 8'hB2;

  localparam logic [7:0] RST_DISCH = 8'h61;
  localparam logic [7:0] RST_PG = 8'h00;
  localparam logic [7:0] RST_FLT = 8'h00;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [7:0] A1_RST_3V3 = 8'h7C;
  localparam logic [7:0] A1_RST_1V8 = 8'h69;
  localparam logic [2:0] I2C_IDLE_SYNC = 3'h7;

  localparam int DISCH_TERM_BIT = 4;
  localparam int A1_DIS_MSB = 7;
  localparam int A1_DIS_LSB = 6;
  localparam int A1_ESD_BIT = 5;
  localparam int A1_VID_MSB = 4;
  localparam int A1_VID_LSB = 1;
  localparam int A1_EN_BIT = 0;
  localparam int PG1_A2_BIT = 7;
  localparam int PG2_FIVE_BIT = 5;
  localparam int PG2_A1_BIT = 4;
  localparam int PG2_TERM_BIT = 3;
  localparam int PG2_A3_BIT = 0;
  localparam logic [7:0] FLT1_KEEP_MASK = 8'hBF;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    DIS_NONE = 2'h0,
    DIS_100_OHM = 2'h1,
    DIS_200_OHM = 2'h2,
    DIS_500_OHM = 2'h3
  } pmicr_dis_t;

  typedef struct packed {
    logic linreg_a2;
    logic [5:0] step_down;
    logic linreg_five;
    logic linreg_a1;
    logic termination;
    logic linreg_a3;
  } pmicr_pg_in_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic sda;
  } pmicr_i2c_ev_t;

endpackage

// ### design/pmicr_i2c_front.sv
// Bus pin synchroniser with clock edge, start and stop detection.
`timescale 1ns/10ps
module pmicr_i2c_front
  import pmicr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output pmicr_i2c_ev_t ev
);

  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
  } pmicr_front_st_t;

  pmicr_front_st_t st_reg;
  pmicr_front_st_t st_next;

  // Stage 0 feeds only stage 1; events look at stages 1 and 2.
  always_comb begin
    st_next = st_reg;
    st_next.scl = {st_reg.scl[1:0], scl_pin};
    st_next.sda = {st_reg.sda[1:0], sda_pin};
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= {I2C_IDLE_SYNC, I2C_IDLE_SYNC};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ev.rise = st_reg.scl[1] & ~st_reg.scl[2];
  assign ev.fall = ~st_reg.scl[1] & st_reg.scl[2];
  assign ev.start = st_reg.scl[1] & st_reg.scl[2] & st_reg.sda[2] & ~st_reg.sda[1];
  assign ev.stop = st_reg.scl[1] & st_reg.scl[2] & ~st_reg.sda[2] & st_reg.sda[1];
  assign ev.sda = st_reg.sda[1];

endmodule

// ### design/pmicr_fault_flags.sv
// Sticky fault flags that hardware sets and the host clears by writing one.
`timescale 1ns/10ps
module pmicr_fault_flags
  import pmicr_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] KEEP = FLT1_KEEP_MASK
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] set_lvl,
  input wire logic [W-1:0] clr_mask,
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } pmicr_flt_st_t;

  pmicr_flt_st_t st_reg;
  pmicr_flt_st_t st_next;
  logic [W-1:0] bit_next;
  logic [W-1:0] set_masked;
  logic [W-1:0] clr_masked;

  assign set_masked = set_lvl & KEEP;
  assign clr_masked = clr_mask & KEEP;

  // A set in the same cycle as a clear keeps the flag.
  for (genvar i = 0; i < W; i++) begin : g_flag
    assign bit_next[i] = set_masked[i] | (st_reg.flags[i] & ~clr_masked[i]);
  end

  always_comb begin
    st_next = st_reg;
    st_next.flags = bit_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg.flags <= RST_FLT[W-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_rail_lost;
    set_masked != '0;
  endsequence

  sequence s_host_clear;
    clr_masked != '0 && set_masked == '0;
  endsequence

  a_flt_set_holds: assert property (s_rail_lost |=> (flags & $past(set_masked)) == $past(set_masked))
    else $error("fault flag not set by lost regulation");
  a_flt_host_clear: assert property (s_host_clear |=> (flags & $past(clr_masked)) == '0)
    else $error("fault flag not cleared by write of one");
  a_flt_sticky: assert property (clr_masked == '0 |=> (flags & $past(flags)) == $past(flags))
    else $error("fault flag dropped without host clear");

endmodule

// ### design/pmicr_ldo_pgood_regs.sv
// Register slice for termination discharge, regulator A1 control, power-good and fault status over the serial port.
`timescale 1ns/10ps
module pmicr_ldo_pgood_regs
  import pmicr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe,
  input pmicr_pg_in_t pg_in,
  input wire logic [7:0] regulation_lost_flag,
  input wire logic emergency_shutdown,
  input wire logic [7:0] otp_a1_reset,
  output logic termination_discharge_select,
  output pmicr_dis_t linreg_a1_discharge_strength,
  output logic linreg_a1_emergency_off_select,
  output logic [3:0] linreg_a1_voltage_code,
  output logic linreg_a1_enable_bit,
  output logic linreg_a1_on
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_ADDR = 9'h004,
    ST_PTR = 9'h008,
    ST_ACK_PTR = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_ACK_R = 9'h100
  } pmicr_state_t;

  typedef struct packed {
    pmicr_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_oe;
    logic sda_o;
    logic [7:0] disch;
    logic [7:0] a1ctl;
    pmicr_pg_in_t pg_s1;
    logic [7:0] pg1;
    logic [7:0] pg2;
    logic esd_s1;
    logic esd_s2;
    logic [7:0] lost_s1;
    logic [7:0] lost_s2;
    logic a1_on;
  } pmicr_st_t;

  pmicr_st_t r;
  pmicr_st_t n;
  pmicr_i2c_ev_t ev;
  logic wr_fire;
  logic [7:0] clr_mask;
  logic [7:0] flt1;
  logic [7:0] rd_now;
  logic [7:0] rd_inc;

  pmicr_i2c_front u_front (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .ev(ev)
  );

  pmicr_fault_flags #(
    .W(8),
    .KEEP(FLT1_KEEP_MASK)
  ) u_flt1 (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set_lvl(r.lost_s2),
    .clr_mask(clr_mask),
    .flags(flt1)
  );

  // Read mux; unmapped addresses return zero.
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = READ_NONE;
    unique case (a)
      ADDR_DISCH: v = r.disch;
      ADDR_A1CTL: v = r.a1ctl;
      ADDR_PG1: v = r.pg1;
      ADDR_PG2: v = r.pg2;
      ADDR_FLT1: v = flt1;
      default: v = READ_NONE;
    endcase
    return v;
  endfunction

  // A process, not a continuous assignment, so that a status byte changing under a fixed pointer is seen.
  always_comb begin
    rd_now = rd_byte(r.ptr);
    rd_inc = rd_byte(r.ptr + 8'h01);
  end
  assign clr_mask = (wr_fire && r.ptr == ADDR_FLT1) ? r.shift : 8'h00;

  always_comb begin
    n = r;
    wr_fire = 1'b0;
    n.sda_o = 1'b0;
    // Power-good bits pass two flops and track the rails live.
    n.pg_s1 = pg_in;
    n.pg1 = {r.pg_s1.linreg_a2, 1'h0, r.pg_s1.step_down};
    n.pg2 = {2'h0, r.pg_s1.linreg_five, r.pg_s1.linreg_a1, r.pg_s1.termination, 2'h0, r.pg_s1.linreg_a3};
    n.esd_s1 = emergency_shutdown;
    n.esd_s2 = r.esd_s1;
    n.lost_s1 = regulation_lost_flag;
    n.lost_s2 = r.lost_s1;
    n.a1_on = r.a1ctl[A1_EN_BIT] & ~(r.esd_s2 & r.a1ctl[A1_ESD_BIT]);
    if (ev.start) begin
      n.state = ST_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (ev.stop) begin
      n.state = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.state)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (ev.rise) begin
            n.shift = {r.shift[6:0], ev.sda};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (ev.fall && r.bitcnt == BYTE_BITS) begin
            n.sda_oe = 1'b1;
            if (r.state == ST_ADDR) begin
              if (r.shift[7:1] == DEV_ADDR) begin
                n.rw = r.shift[0];
                n.state = ST_ACK_ADDR;
              end else begin
                n.sda_oe = 1'b0;
                n.state = ST_IDLE;
              end
            end else if (r.state == ST_PTR) begin
              n.ptr = r.shift;
              n.state = ST_ACK_PTR;
            end else begin
              wr_fire = 1'b1;
              n.state = ST_ACK_W;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (ev.fall) begin
            n.bitcnt = 4'h0;
            if (r.rw) begin
              n.shift = rd_now;
              n.sda_oe = ~rd_now[7];
              n.state = ST_RDATA;
            end else begin
              n.sda_oe = 1'b0;
              n.state = ST_PTR;
            end
          end
        end
        ST_ACK_PTR, ST_ACK_W: begin
          if (ev.fall) begin
            n.sda_oe = 1'b0;
            n.bitcnt = 4'h0;
            n.state = ST_WDATA;
            if (r.state == ST_ACK_W) begin
              n.ptr = r.ptr + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (ev.rise) begin
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (ev.fall) begin
            if (r.bitcnt == BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.state = ST_ACK_R;
            end else begin
              n.shift = {r.shift[6:0], 1'b0};
              n.sda_oe = ~r.shift[6];
            end
          end
        end
        ST_ACK_R: begin
          if (ev.rise) begin
            n.mack = ~ev.sda;
          end else if (ev.fall) begin
            if (r.mack) begin
              n.ptr = r.ptr + 8'h01;
              n.shift = rd_inc;
              n.sda_oe = ~rd_inc[7];
              n.bitcnt = 4'h0;
              n.state = ST_RDATA;
            end else begin
              n.state = ST_IDLE;
            end
          end
        end
      endcase
    end
    // Completed write bytes land here; power-good bytes ignore writes, and a fault byte write clears flags through clr_mask.
    if (wr_fire) begin
      if (r.ptr == ADDR_DISCH) begin
        n.disch = r.shift;
      end else if (r.ptr == ADDR_A1CTL) begin
        n.a1ctl = r.shift;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r.state <= ST_IDLE;
      r.bitcnt <= 4'h0;
      r.shift <= 8'h00;
      r.ptr <= RST_PTR;
      r.rw <= 1'b0;
      r.mack <= 1'b0;
      r.sda_oe <= 1'b0;
      r.sda_o <= 1'b0;
      r.disch <= RST_DISCH;
      r.a1ctl <= otp_a1_reset;
      r.pg_s1 <= '0;
      r.pg1 <= RST_PG;
      r.pg2 <= RST_PG;
      r.esd_s1 <= 1'b0;
      r.esd_s2 <= 1'b0;
      r.lost_s1 <= 8'h00;
      r.lost_s2 <= 8'h00;
      r.a1_on <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign sda_out = r.sda_o;
  assign sda_oe = r.sda_oe;
  assign termination_discharge_select = r.disch[DISCH_TERM_BIT];
  assign linreg_a1_discharge_strength = pmicr_dis_t'(r.a1ctl[A1_DIS_MSB:A1_DIS_LSB]);
  assign linreg_a1_emergency_off_select = r.a1ctl[A1_ESD_BIT];
  assign linreg_a1_voltage_code = r.a1ctl[A1_VID_MSB:A1_VID_LSB];
  assign linreg_a1_enable_bit = r.a1ctl[A1_EN_BIT];
  assign linreg_a1_on = r.a1_on;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_wr(logic [7:0] a);
    wr_fire && r.ptr == a;
  endsequence

  a_disch_reset_val: assert property (@(posedge sys_clk) disable iff (1'b0) !rstn |=> r.disch == RST_DISCH)
    else $error("discharge byte reset value wrong");
  a_disch_write_all: assert property (s_wr(ADDR_DISCH) |=> r.disch == $past(r.shift))
    else $error("discharge byte not fully writable");
  a_term_select_map: assert property (s_wr(ADDR_DISCH) |=> termination_discharge_select == $past(r.shift[4]))
    else $error("termination discharge select not from bit 4");
  a_a1_reset_otp: assert property (@(posedge sys_clk) disable iff (1'b0) !rstn |=> r.a1ctl == $past(otp_a1_reset))
    else $error("A1 control reset not from programmed value");
  a_a1_field_map: assert property (s_wr(ADDR_A1CTL) |=> linreg_a1_voltage_code == $past(r.shift[4:1])
    && linreg_a1_discharge_strength == $past(r.shift[7:6]))
    else $error("A1 control fields mapped wrong");
  a_a1_esd_off: assert property (r.esd_s2 && r.a1ctl[A1_ESD_BIT] |=> !linreg_a1_on)
    else $error("A1 stays on in emergency shutdown");
  a_a1_esd_keep: assert property (!r.a1ctl[A1_ESD_BIT] |=> linreg_a1_on == $past(r.a1ctl[A1_EN_BIT]))
    else $error("A1 on state does not follow enable bit");
  a_a1_write_all: assert property (s_wr(ADDR_A1CTL) |=> r.a1ctl == $past(r.shift))
    else $error("A1 control byte not fully writable");
  a_disch_hold: assert property (!(wr_fire && r.ptr == ADDR_DISCH) |=> $stable(r.disch))
    else $error("discharge byte changed without a write");
  a_pg_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0) !rstn |=> r.pg1 == RST_PG && r.pg2 == RST_PG)
    else $error("power-good bytes not zero at reset");
  a_pg1_live_map: assert property ($past(rstn, 2) |-> r.pg1 == {$past(pg_in.linreg_a2, 2), 1'h0,
    $past(pg_in.step_down, 2)})
    else $error("first power-good byte not live rail state");
  a_pg2_live_map: assert property ($past(rstn, 2) |-> r.pg2[PG2_FIVE_BIT] == $past(pg_in.linreg_five, 2)
    && r.pg2[PG2_A1_BIT] == $past(pg_in.linreg_a1, 2) && r.pg2[PG2_TERM_BIT] == $past(pg_in.termination, 2)
    && r.pg2[PG2_A3_BIT] == $past(pg_in.linreg_a3, 2))
    else $error("second power-good byte mapped wrong");
  a_pg_reserved_zero: assert property (r.pg1[6] == 1'b0 && r.pg2[7:6] == 2'h0 && r.pg2[2:1] == 2'h0)
    else $error("reserved power-good bit not zero");
  a_flt_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0) !rstn |=> flt1 == RST_FLT)
    else $error("fault byte not cleared at reset");

endmodule

// ### tb/pmicr_host_model.sv
// Serial bus host model that performs register writes and reads over the open-drain data line.
`timescale 1ns/10ps
module pmicr_host_model
  import pmicr_pkg::*;
#(
  parameter int Q = 6
)
(
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic step();
    repeat (Q) @(posedge sys_clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    step();
    scl <= 1'b1;
    step();
    sda_low <= 1'b1;
    step();
    scl <= 1'b0;
    step();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    step();
    scl <= 1'b1;
    step();
    sda_low <= 1'b0;
    step();
  endtask
  // Data changes only while the clock is low and is sampled in the middle of the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    step();
    scl <= 1'b1;
    step();
    r = sda_line;
    step();
    scl <= 1'b0;
    step();
  endtask
  // Eight bits out, then the line is released and the ninth bit read as acknowledge.
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    byte_io({dv, 1'b0}, r, k1);
    byte_io(a, r, k2);
    byte_io(d, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // Two-byte write to consecutive registers.
  task automatic wr2(input logic [6:0] dv, input logic [7:0] a, input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start();
    byte_io({dv, 1'b0}, r, k1);
    byte_io(a, r, k2);
    byte_io(d[15:8], r, k3);
    byte_io(d[7:0], r, k4);
    stop();
    ok = k1 & k2 & k3 & k4;
  endtask
  // Two-byte read: the host acknowledges the first byte and refuses the second.
  task automatic rd2(input logic [6:0] dv, input logic [7:0] a, output logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic s;
    logic k1, k2, k3, k4;
    start();
    byte_io({dv, 1'b0}, r, k1);
    byte_io(a, r, k2);
    start();
    byte_io({dv, 1'b1}, r, k3);
    for (int i = 15; i >= 8; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b0, s);
    byte_io(8'hFF, r, k4);
    d[7:0] = r;
    stop();
    ok = k1 & k2 & k3;
  endtask
  // Read ends with a not-acknowledge from the host.
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start();
    byte_io({dv, 1'b0}, r, k1);
    byte_io(a, r, k2);
    start();
    byte_io({dv, 1'b1}, r, k3);
    byte_io(8'hFF, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule

// ### tb/tb.sv
// Testbench for the regulator register slice driven through the serial host model.
`timescale 1ns/10ps
module tb
  import pmicr_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A;
  logic sys_clk;
  logic rstn;
  logic scl;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  wire sda_line;
  pmicr_pg_in_t pg_in;
  logic [7:0] regulation_lost_flag;
  logic emergency_shutdown;
  logic [7:0] otp_a1_reset;
  logic termination_discharge_select;
  pmicr_dis_t linreg_a1_discharge_strength;
  logic linreg_a1_emergency_off_select;
  logic [3:0] linreg_a1_voltage_code;
  logic linreg_a1_enable_bit;
  logic linreg_a1_on;
  int n_errors;
  int compares;
  logic ok;
  logic [7:0] rv;
  logic [15:0] rv2;
  // Pulled-up data line: low whenever any party pulls it.
  assign sda_line = host_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  pmicr_ldo_pgood_regs #(.DEV_ADDR(DEV)) pmicr_ldo_pgood_regs_inst (
    .sys_clk(sys_clk), .rstn(rstn), .scl_pin(scl), .sda_pin(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .pg_in(pg_in), .regulation_lost_flag(regulation_lost_flag),
    .emergency_shutdown(emergency_shutdown), .otp_a1_reset(otp_a1_reset),
    .termination_discharge_select(termination_discharge_select),
    .linreg_a1_discharge_strength(linreg_a1_discharge_strength),
    .linreg_a1_emergency_off_select(linreg_a1_emergency_off_select),
    .linreg_a1_voltage_code(linreg_a1_voltage_code), .linreg_a1_enable_bit(linreg_a1_enable_bit),
    .linreg_a1_on(linreg_a1_on));
  pmicr_host_model pmicr_host_model_inst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    pmicr_host_model_inst.wr(DEV, a, d, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    pmicr_host_model_inst.rd(DEV, a, rv, ok);
    check("read ack", {7'h00, ok}, 8'h01);
    check(what, rv, exp);
  endtask
  task automatic wait_on(input logic exp);
    int k;
    k = 0;
    while (linreg_a1_on !== exp && k < 10) begin
      @(posedge sys_clk);
      k++;
    end
    if (linreg_a1_on !== exp) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic pg_case(input pmicr_pg_in_t p, input logic [7:0] e1, input logic [7:0] e2);
    pg_in <= p;
    repeat (4) @(posedge sys_clk);
    reg_rd(ADDR_PG1, e1, "pg1");
    reg_rd(ADDR_PG2, e2, "pg2");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    n_errors = 0;
    compares = 0;
    rstn = 1'b0;
    pg_in = '0;
    regulation_lost_flag = 8'h00;
    emergency_shutdown = 1'b0;
    otp_a1_reset = A1_RST_3V3;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_rd(ADDR_DISCH, RST_DISCH, "disch rst");
    reg_rd(ADDR_A1CTL, A1_RST_3V3, "a1 rst");
    check("a1 strength", {6'h00, linreg_a1_discharge_strength}, {6'h00, DIS_100_OHM});
    check("a1 off sel", {7'h00, linreg_a1_emergency_off_select}, 8'h01);
    check("a1 vcode", {4'h0, linreg_a1_voltage_code}, 8'h0E);
    check("a1 en", {7'h00, linreg_a1_enable_bit}, 8'h00);
    reg_rd(ADDR_PG1, RST_PG, "pg1 rst");
    reg_rd(ADDR_PG2, RST_PG, "pg2 rst");
    reg_rd(ADDR_FLT1, RST_FLT, "flt rst");
    $display("test reset values done");
    reg_wr(ADDR_DISCH, 8'h9E);
    reg_rd(ADDR_DISCH, 8'h9E, "disch rw");
    check("term sel on", {7'h00, termination_discharge_select}, 8'h01);
    reg_wr(ADDR_DISCH, 8'h61);
    check("term sel off", {7'h00, termination_discharge_select}, 8'h00);
    $display("test discharge byte done");
    for (int i = 0; i < 4; i++) begin
      reg_wr(ADDR_A1CTL, {i[1:0], 6'h09});
      check("a1 strength", {6'h00, linreg_a1_discharge_strength}, {6'h00, i[1:0]});
      check("a1 vcode", {4'h0, linreg_a1_voltage_code}, 8'h04);
      check("a1 on", {7'h00, linreg_a1_on}, 8'h01);
    end
    reg_rd(ADDR_A1CTL, 8'hC9, "a1 rw");
    $display("test a1 control done");
    emergency_shutdown <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("a1 kept on", {7'h00, linreg_a1_on}, 8'h01);
    reg_wr(ADDR_A1CTL, 8'h69);
    check("a1 off esd", {7'h00, linreg_a1_on}, 8'h00);
    emergency_shutdown <= 1'b0;
    wait_on(1'b1);
    check("a1 back on", {7'h00, linreg_a1_on}, 8'h01);
    reg_wr(ADDR_A1CTL, 8'h68);
    check("a1 disabled", {7'h00, linreg_a1_on}, 8'h00);
    $display("test emergency shutdown done");
    pg_case(11'h6AA, 8'hAA, 8'h28);
    pg_case(11'h155, 8'h15, 8'h11);
    reg_wr(ADDR_PG1, 8'hFF);
    reg_wr(ADDR_PG2, 8'hFF);
    reg_rd(ADDR_PG1, 8'h15, "pg1 ro");
    reg_rd(ADDR_PG2, 8'h11, "pg2 ro");
    pg_case(11'h7FF, 8'hBF, 8'h39);
    pg_case(11'h000, 8'h00, 8'h00);
    $display("test power good done");
    regulation_lost_flag <= 8'hFF;
    repeat (6) @(posedge sys_clk);
    regulation_lost_flag <= 8'h00;
    repeat (6) @(posedge sys_clk);
    reg_rd(ADDR_FLT1, 8'hBF, "flt set");
    reg_wr(ADDR_FLT1, 8'h01);
    reg_rd(ADDR_FLT1, 8'hBE, "flt w1c one");
    reg_wr(ADDR_FLT1, 8'hFF);
    reg_rd(ADDR_FLT1, 8'h00, "flt w1c all");
    regulation_lost_flag <= 8'h80;
    repeat (6) @(posedge sys_clk);
    reg_wr(ADDR_FLT1, 8'h80);
    reg_rd(ADDR_FLT1, 8'h80, "flt set wins");
    regulation_lost_flag <= 8'h00;
    repeat (6) @(posedge sys_clk);
    reg_wr(ADDR_FLT1, 8'h80);
    reg_rd(ADDR_FLT1, 8'h00, "flt clear after");
    $display("test fault flags done");
    reg_rd(8'hC0, READ_NONE, "unmapped");
    pmicr_host_model_inst.wr(DEV ^ 7'h01, ADDR_DISCH, 8'h00, ok);
    check("bad dev ack", {7'h00, ok}, 8'h00);
    reg_rd(ADDR_DISCH, RST_DISCH, "bad dev ignored");
    $display("test refusals done");
    pmicr_host_model_inst.wr2(DEV, ADDR_DISCH, 16'h10C9, ok);
    check("burst wr ack", {7'h00, ok}, 8'h01);
    pmicr_host_model_inst.rd2(DEV, ADDR_DISCH, rv2, ok);
    check("burst rd ack", {7'h00, ok}, 8'h01);
    check("burst disch", rv2[15:8], 8'h10);
    check("burst a1", rv2[7:0], 8'hC9);
    check("term sel burst", {7'h00, termination_discharge_select}, 8'h01);
    check("a1 strength burst", {6'h00, linreg_a1_discharge_strength}, {6'h00, DIS_500_OHM});
    $display("test burst access done");
    reg_wr(ADDR_DISCH, 8'h00);
    otp_a1_reset <= A1_RST_1V8;
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_rd(ADDR_DISCH, RST_DISCH, "disch rerst");
    reg_rd(ADDR_A1CTL, A1_RST_1V8, "a1 rerst");
    check("a1 vcode 1v8", {4'h0, linreg_a1_voltage_code}, 8'h04);
    check("a1 en 1v8", {7'h00, linreg_a1_enable_bit}, 8'h01);
    $display("test second reset done");
    summarize();
  end
endmodule
